// ### verification/can_acceptance_filter_routing_test.sv
// Self-checking bench for the CAN filter routing block
`timescale 1ns/1ps
module can_acceptance_filter_routing_test;
   logic core_clk, rstn, psel, penable, pwrite, send, pready, pslverr, msg_valid, er; // Controls
   logic [11:0] paddr; // Bus address
   logic [31:0] pwdata, prdata, rd, ctrl, rnd, filter_cfg; // Data and model word
   logic [3:0] pstrb; // Byte lanes
   logic [15:0] hits, lfsr, cnt; // Hits, random state, routed count
   logic [3:0][3:0] mask_hit; // Hits at the design
   cfr_pkg::cfr_route_type route; // Routing answer
   int fails, n_checks, cyc = 0; // Counters
   cfr_top cfr_top_i (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .mask_hit(mask_hit),
      .route(route), .filter_cfg(filter_cfg));
   cfr_rx_model cfr_rx_model_i (.core_clk(core_clk), .send(send), .hits(hits),
      .msg_valid(msg_valid), .mask_hit(mask_hit));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         wrap_up();
      end
   end
   // Random source
   function automatic logic [15:0] step(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One transfer, held until pready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Write, update model, read back
   task automatic wr(logic [31:0] d, logic [3:0] s);
      apb(1'b1, cfr_pkg::CFR_CTRL_OFF, d, s);
      for (int i = 0; i < 4; i++) begin
         if (s[i] && ctrl[8*i+7]) ctrl[8*i+7] = d[8*i+7];
         else if (s[i]) ctrl[8*i+:8] = d[8*i+:8];
      end
      apb(1'b0, cfr_pkg::CFR_CTRL_OFF, 32'h0, 4'h0);
      chk(rd, ctrl);
      chk(filter_cfg, ctrl);
   endtask
   // Message and expected route: lowest enabled hitting filter wins
   task automatic msg(logic [15:0] h);
      logic [7:0] e;
      e = 8'h00;
      for (int f = 3; f >= 0; f--) begin
         if (ctrl[8*f+7] && h[4*f+ctrl[8*f+5+:2]]) e = {1'b1, 2'(f), ctrl[8*f+:5]};
      end
      if (e[7]) cnt = cnt + 16'h0001;
      @(posedge core_clk);
      send <= 1'b1;
      hits <= h;
      @(posedge core_clk);
      send <= 1'b0;
      @(posedge core_clk);
      #1 chk(route, e);
   endtask
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, send, paddr, pwdata, pstrb, hits} = '0;
      {fails, n_checks} = '0;
      ctrl = 32'h0;
      cnt = 16'h0000;
      lfsr = 16'h0051;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      apb(1'b0, cfr_pkg::CFR_CTRL_OFF, 32'h0, 4'h0);
      chk(rd, 32'h0);
      msg(16'hffff);
      apb(1'b1, 12'h008, 32'hffff_ffff, 4'hf);
      chk(er, 1'b1);
      apb(1'b0, 12'hffc, 32'h0, 4'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, cfr_pkg::CFR_STAT_OFF, 32'h0, 4'h0);
      chk(er, 1'b0);
      chk(rd, 32'h0);
      repeat (60) begin
         lfsr = step(lfsr);
         rnd = {lfsr, step(lfsr)};
         wr(rnd, lfsr[7:4]);
         repeat (2) begin
            lfsr = step(lfsr);
            msg(lfsr);
         end
      end
      // Status count of routed messages, route idle by now
      apb(1'b0, cfr_pkg::CFR_STAT_OFF, 32'h0, 4'h0);
      chk(rd, {cnt, 16'h0000});
      // Reset in mid-run clears control word and count
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      ctrl = 32'h0;
      cnt = 16'h0000;
      apb(1'b0, cfr_pkg::CFR_CTRL_OFF, 32'h0, 4'h0);
      chk(rd, ctrl);
      chk(filter_cfg, ctrl);
      apb(1'b0, cfr_pkg::CFR_STAT_OFF, 32'h0, 4'h0);
      chk(rd, {cnt, 16'h0000});
      msg(16'hffff);
      wrap_up();
   end
endmodule

// ### verification/cfr_rx_model.sv
// Receive engine model presenting messages and their filter hits
`timescale 1ns/1ps
module cfr_rx_model (
   input wire logic core_clk,
   input wire logic send,
   input wire logic [15:0] hits,
   output logic msg_valid,
   output logic [3:0][3:0] mask_hit
);
   // One-cycle message; hit lines show the inverse between messages
   always @(posedge core_clk) begin
      msg_valid <= send;
      mask_hit <= send ? hits : ~hits;
   end
endmodule

// ### verilog/cfr_filter_slot.sv
// One filter slot: guarded field update and mask-selected acceptance
`timescale 1ns/1ps
module cfr_filter_slot (
   input wire cfr_pkg::cfr_filter_type cur,
   input wire logic [7:0] wr_byte,
   input wire logic wr_en,
   input wire logic [3:0] mask_hit,
   output cfr_pkg::cfr_filter_type nxt,
   output logic hit
);
   // Incoming write viewed as filter fields
   cfr_pkg::cfr_filter_type wr_fields;
   assign wr_fields = cfr_pkg::cfr_filter_type'(wr_byte);

   // While enabled, only the enable bit may change; the rest is frozen
   assign nxt.enable = wr_en ? wr_fields.enable : cur.enable;
   assign nxt.mask_sel = (wr_en && !cur.enable) ? wr_fields.mask_sel : cur.mask_sel;
   assign nxt.fifo_sel = (wr_en && !cur.enable) ? wr_fields.fifo_sel : cur.fifo_sel;

   // Match against the selected mask, only when the filter is on
   assign hit = cur.enable && mask_hit[cur.mask_sel];
endmodule

// ### verilog/cfr_pkg.sv
// Shared constants and types for the CAN acceptance filter routing block
package cfr_pkg;

   // Register byte addresses
   localparam logic [11:0] CFR_CTRL_OFF = 12'h000; // Filter control, filters 16 to 19
   localparam logic [11:0] CFR_STAT_OFF = 12'h004; // Routing status
   localparam int CFR_ADDR_W = 12; // APB address width

   // Layout of one filter byte inside the control word
   localparam int CFR_EN_POS = 7; // Enable bit
   localparam int CFR_MSEL_LSB = 5; // Mask selector, two bits
   localparam int CFR_FSEL_LSB = 0; // FIFO selector, five bits
   localparam int CFR_LANE_W = 8; // Bits per filter
   localparam int CFR_NUM_FILT = 4; // Filters in this register
   localparam int CFR_NUM_MASK = 4; // Acceptance masks
   localparam logic [31:0] CFR_CTRL_RESET = 32'h0000_0000; // All filters off

   // One filter's control fields, packed in register order
   typedef struct packed {
      logic enable; // Filter takes part in acceptance
      logic [1:0] mask_sel; // Acceptance mask in use
      logic [4:0] fifo_sel; // Destination message FIFO
   } cfr_filter_type;

   // Routing decision handed to the receive engine
   typedef struct packed {
      logic valid; // A filter accepted the message
      logic [1:0] filter; // Winning filter, 0 means filter 16
      logic [4:0] fifo; // FIFO buffer to store in
   } cfr_route_type;

endpackage

// ### verilog/cfr_top.sv
// APB register and routing logic for CAN acceptance filters 16 to 19
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module cfr_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic msg_valid,
   input wire logic [3:0][3:0] mask_hit,
   output cfr_pkg::cfr_route_type route,
   output logic [31:0] filter_cfg
);

   // State
   logic [31:0] ctrl_reg; // Filter control word
   logic [31:0] ctrl_next; // Control word after a write
   logic [31:0] prdata_reg; // Read data held for access phase
   logic pready_reg; // Access answer
   logic pslverr_reg; // Unmapped address flag
   cfr_pkg::cfr_route_type route_reg; // Last routing decision
   cfr_pkg::cfr_route_type route_next; // Routing decision this cycle
   logic [15:0] route_cnt_reg; // Messages routed since reset

   // Bus decode
   wire sel_ctrl = (paddr == cfr_pkg::CFR_CTRL_OFF); // Control word hit
   wire sel_stat = (paddr == cfr_pkg::CFR_STAT_OFF); // Status word hit
   wire mapped = sel_ctrl | sel_stat; // Any known address
   wire access = psel & penable; // Access phase
   wire commit = access & pready_reg; // Edge where transfer completes
   wire ctrl_wr = commit & pwrite & sel_ctrl; // Control write takes effect
   wire [31:0] stat_word = {route_cnt_reg, 5'h00, route_reg.valid, route_reg.filter,
                            3'h0, route_reg.fifo}; // Status view
   wire [31:0] rd_mux = sel_ctrl ? ctrl_reg : (sel_stat ? stat_word : 32'h0000_0000);

   // Per-filter slots, filter 16 in byte lane 0 up to filter 19 in lane 3
   logic [3:0] hit; // Filter accepted the message
   genvar gi;
   generate
      for (gi = 0; gi < cfr_pkg::CFR_NUM_FILT; gi++) begin : g_slot
         cfr_pkg::cfr_filter_type slot_nxt; // Next fields of this filter
         cfr_filter_slot u_slot (
            .cur(cfr_pkg::cfr_filter_type'(ctrl_reg[gi*8 +: 8])),
            .wr_byte(pwdata[gi*8 +: 8]),
            .wr_en(ctrl_wr & pstrb[gi]),
            .mask_hit(mask_hit[gi]),
            .nxt(slot_nxt),
            .hit(hit[gi])
         );
         assign ctrl_next[gi*8 +: 8] = slot_nxt;
      end
   endgenerate

   // Lowest numbered matching filter wins
   always_comb begin
      route_next = '0;
      for (int i = cfr_pkg::CFR_NUM_FILT - 1; i >= 0; i--) begin
         if (msg_valid && hit[i]) begin
            route_next.valid = 1'b1;
            route_next.filter = 2'(i);
            route_next.fifo = ctrl_reg[i*8 + cfr_pkg::CFR_FSEL_LSB +: 5];
         end
      end
   end

   // Control register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrl_reg <= cfr_pkg::CFR_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // APB answer: one wait state, then ready for one cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access & ~pready_reg;
         prdata_reg <= (access & ~pready_reg & ~pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_reg <= access & ~pready_reg & ~mapped;
      end
   end

   // Routing result and counter
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         route_reg <= '0;
         route_cnt_reg <= 16'h0000;
      end else begin
         route_reg <= route_next;
         if (route_next.valid) begin
            route_cnt_reg <= route_cnt_reg + 16'h0001;
         end
      end
   end

   // Outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign route = route_reg;
   assign filter_cfg = ctrl_reg;

   // Checks
   property p_reset_clear;
      @(posedge core_clk) !rstn |=> (ctrl_reg == 32'h0000_0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("control not cleared by reset");

   property p_off_no_route;
      @(posedge core_clk) disable iff (!rstn)
         (msg_valid && ctrl_reg[31] == 1'b0 && ctrl_reg[23] == 1'b0
          && ctrl_reg[15] == 1'b0 && ctrl_reg[7] == 1'b0) |=> !route.valid;
   endproperty
   a_off_no_route: assert property (p_off_no_route)
      else $error("disabled filter routed");

   property p_mask_miss;
      @(posedge core_clk) disable iff (!rstn)
         (msg_valid && ctrl_reg[7] && !mask_hit[0][ctrl_reg[6:5]]
          && !ctrl_reg[15] && !ctrl_reg[23] && !ctrl_reg[31]) |=> !route.valid;
   endproperty
   a_mask_miss: assert property (p_mask_miss) else $error("wrong mask used");

   property p_fifo_route;
      @(posedge core_clk) disable iff (!rstn)
         (msg_valid && ctrl_reg[7] && mask_hit[0][ctrl_reg[6:5]])
         |=> (route.valid && route.filter == 2'd0 && route.fifo == $past(ctrl_reg[4:0]));
   endproperty
   a_fifo_route: assert property (p_fifo_route)
      else $error("message sent to wrong FIFO");

   property p_lock19;
      @(posedge core_clk) disable iff (!rstn)
         ctrl_reg[31] |=> (ctrl_reg[30:24] == $past(ctrl_reg[30:24]));
   endproperty
   a_lock19: assert property (p_lock19) else $error("filter 19 changed while on");

   property p_lock18;
      @(posedge core_clk) disable iff (!rstn)
         ctrl_reg[23] |=> (ctrl_reg[22:16] == $past(ctrl_reg[22:16]));
   endproperty
   a_lock18: assert property (p_lock18) else $error("filter 18 changed while on");

   property p_lock17;
      @(posedge core_clk) disable iff (!rstn)
         ctrl_reg[15] |=> (ctrl_reg[14:8] == $past(ctrl_reg[14:8]));
   endproperty
   a_lock17: assert property (p_lock17) else $error("filter 17 changed while on");

   property p_lock16;
      @(posedge core_clk) disable iff (!rstn)
         ctrl_reg[7] |=> (ctrl_reg[6:0] == $past(ctrl_reg[6:0]));
   endproperty
   a_lock16: assert property (p_lock16) else $error("filter 16 changed while on");

   property p_write_free;
      @(posedge core_clk) disable iff (!rstn)
         (ctrl_wr && pstrb[0] && !ctrl_reg[7])
         |=> (ctrl_reg[7:0] == $past(pwdata[7:0]));
   endproperty
   a_write_free: assert property (p_write_free)
      else $error("write to idle filter lost");

   // Idle filter 17 takes a full lane write
   property p_write_free17;
      @(posedge core_clk) disable iff (!rstn)
         (ctrl_wr && pstrb[1] && !ctrl_reg[15])
         |=> (ctrl_reg[15:8] == $past(pwdata[15:8]));
   endproperty
   a_write_free17: assert property (p_write_free17)
      else $error("write to idle filter 17 lost");

   // Idle filter 18 takes a full lane write
   property p_write_free18;
      @(posedge core_clk) disable iff (!rstn)
         (ctrl_wr && pstrb[2] && !ctrl_reg[23])
         |=> (ctrl_reg[23:16] == $past(pwdata[23:16]));
   endproperty
   a_write_free18: assert property (p_write_free18)
      else $error("write to idle filter 18 lost");

   // Idle filter 19 takes a full lane write
   property p_write_free19;
      @(posedge core_clk) disable iff (!rstn)
         (ctrl_wr && pstrb[3] && !ctrl_reg[31])
         |=> (ctrl_reg[31:24] == $past(pwdata[31:24]));
   endproperty
   a_write_free19: assert property (p_write_free19)
      else $error("write to idle filter 19 lost");

   // Filter 19 alone routes to its own FIFO field
   property p_fifo_route19;
      @(posedge core_clk) disable iff (!rstn)
         (msg_valid && ctrl_reg[31] && mask_hit[3][ctrl_reg[30:29]]
          && !ctrl_reg[23] && !ctrl_reg[15] && !ctrl_reg[7])
         |=> (route.valid && route.filter == 2'd3 && route.fifo == $past(ctrl_reg[28:24]));
   endproperty
   a_fifo_route19: assert property (p_fifo_route19)
      else $error("filter 19 message sent to wrong FIFO");

   // No message, no routing decision
   property p_no_msg_route;
      @(posedge core_clk) disable iff (!rstn)
         !msg_valid |=> !route.valid;
   endproperty
   a_no_msg_route: assert property (p_no_msg_route)
      else $error("route without message");

   // Reset quiets the routing and bus answers
   property p_reset_route;
      @(posedge core_clk) !rstn |=> (!route.valid && !pready && !pslverr);
   endproperty
   a_reset_route: assert property (p_reset_route)
      else $error("outputs active after reset");

endmodule
